/* File: hdl/pls_pkg.sv */
package pls_pkg;
    // Line buffer geometry
    localparam int         LINE_LEN  = 217;
    localparam logic [7:0] LAST_COL  = 8'hd8;
    // Buffer byte codes
    localparam logic [7:0] CH_EMPTY  = 8'h00;
    localparam logic [7:0] CH_SPACE  = 8'h20;
    localparam logic [7:0] SLEW_MARK = 8'hff;
    localparam logic [7:0] SLEW_RUN  = 8'h05;
    // Answerback echo and length
    localparam logic [7:0] CARET     = 8'h5e;
    localparam logic [7:0] CTRL_LIM  = 8'h20;
    localparam logic [7:0] CTRL_OFS  = 8'h40;
    localparam logic [4:0] AB_MAX    = 5'h1e;
    // Bell tone select
    localparam logic       TONE_400  = 1'b0;
    localparam logic       TONE_2400 = 1'b1;
    // Output word kinds
    typedef enum logic [2:0] {
        K_DIR  = 3'h0,
        K_BELL = 3'h1,
        K_CHAR = 3'h2,
        K_SLEW = 3'h3,
        K_LF   = 3'h4,
        K_ECHO = 3'h5
    } pls_kind_t;
    // Print process states
    typedef enum logic [3:0] {
        S_INIT  = 4'h0,
        S_IDLE  = 4'h1,
        S_FIND  = 4'h3,
        S_COMP  = 4'h2,
        S_SPACE = 4'h6,
        S_MARK  = 4'h7,
        S_DIR   = 4'h5,
        S_BELL  = 4'h4,
        S_EMIT  = 4'hc,
        S_LF    = 4'hd,
        S_CLEAR = 4'hf
    } pls_state_t;
endpackage : pls_pkg

/* File: hdl/pls_top.sv */
`timescale 1ns/1ps
module pls_top
    import pls_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       wr_valid_i,    // Character deposit
    input  wire logic [7:0] wr_col_i,
    input  wire logic [7:0] wr_char_i,
    input  wire logic       line_end_i,    // Line complete
    input  wire logic [3:0] line_bell_i,
    input  wire logic       line_tone_i,
    input  wire logic [7:0] line_lf_i,
    output logic            wr_ready_o,
    output logic            out_valid_o,   // Print word stream
    input  wire logic       out_ready_i,
    output pls_kind_t       out_kind_o,
    output logic [7:0]      out_col_o,
    output logic [7:0]      out_data_o,
    input  wire logic       cfg_mode_i,    // Answerback entry
    input  wire logic       answerback_program_key_i,
    input  wire logic       key_valid_i,
    input  wire logic [7:0] key_char_i,
    output logic            key_ready_o,
    output logic            ab_entry_o,
    output logic [4:0]      ab_len_o,
    input  wire logic [4:0] ab_rd_addr_i,
    output logic [7:0]      ab_rd_data_o,
    output logic            nv_save_o,
    output logic            param_load_o
);
    logic [7:0] mem [2][LINE_LEN];   // Two line buffers
    logic [7:0] ab_mem [AB_MAX];     // Answerback string
    pls_state_t st_r;
    logic       fsel_r, pend_r, novp_r, ovp_r, brk_r, pvm_r, rev_r, fnd_r;
    logic       hold_v_r, ntone_r, tone_r, boot_r, ab_on_r, ab_ovf_r;
    logic [7:0] hold_col_r, hold_chr_r, nlf_r, lf_r;
    logic [3:0] nbell_r, bell_r;
    logic [7:0] c_r, lft_r, rgt_r, last_r, run_r, stt_r;
    logic [1:0] stp_r, echo_r, cnt_r;
    logic [7:0] echo_chr_r;
    pls_kind_t  k1_r;                // Second FIFO entry
    logic [7:0] c1_r, d1_r;

    // Buffer decode
    wire        psel_w  = ~fsel_r;
    wire [7:0]  pb_w    = mem[psel_w][c_r];
    wire [7:0]  nx_w    = rev_r ? mem[psel_w][c_r - 8'h01] : mem[psel_w][c_r + 8'h01];
    wire        wr_acc  = wr_valid_i && wr_ready_o && (wr_col_i <= LAST_COL);
    wire        ovp_hit = wr_acc && (mem[fsel_r][wr_col_i] != CH_EMPTY);
    wire        end_acc = line_end_i && wr_ready_o && !ovp_hit;
    wire        swap_w  = pend_r && (st_r == S_IDLE);
    // Direction decision
    wire        fnd_w   = fnd_r || (pb_w != CH_EMPTY);
    wire [7:0]  lft_w   = fnd_r ? lft_r : c_r;
    wire [7:0]  rgt_w   = (pb_w != CH_EMPTY) ? c_r : rgt_r;
    wire [7:0]  dl_w    = (lft_w > last_r) ? lft_w - last_r : last_r - lft_w;
    wire [7:0]  dr_w    = (rgt_w > last_r) ? rgt_w - last_r : last_r - rgt_w;
    wire        rev_w   = brk_r && !ovp_r && fnd_w && (dr_w < dl_w);
    wire [7:0]  end_w   = rev_r ? lft_r : rgt_r;
    wire [7:0]  step_w  = rev_r ? c_r - 8'h01 : c_r + 8'h01;
    // FIFO arbitration, echo first
    wire        space_w = (cnt_r != 2'd2);
    wire        pop_w   = out_valid_o && out_ready_i;
    wire        echo_go = space_w && (echo_r != 2'd0);
    wire        want_w  = (st_r == S_DIR) || (st_r == S_EMIT) ||
                          ((st_r == S_BELL) && (bell_r != 4'h0)) || ((st_r == S_LF) && (lf_r != 8'h00));
    wire        prn_go  = space_w && (echo_r == 2'd0) && want_w;
    wire        push_w  = echo_go || prn_go;
    pls_kind_t  pk_w;
    logic [7:0] pc_w, pd_w;
    assign pk_w = echo_go ? K_ECHO : (st_r == S_DIR) ? K_DIR : (st_r == S_BELL) ? K_BELL :
                  (st_r == S_LF) ? K_LF : (pb_w == SLEW_MARK) ? K_SLEW : K_CHAR;
    assign pc_w = (pk_w == K_SLEW) ? nx_w : (pk_w == K_CHAR) ? c_r : 8'h00;
    assign pd_w = echo_go ? ((echo_r == 2'd2) ? CARET : echo_chr_r) :
                  (st_r == S_DIR) ? {7'h00, rev_r} :
                  (st_r == S_BELL) ? {3'h0, tone_r, bell_r} :
                  (st_r == S_LF) ? lf_r : (pk_w == K_CHAR) ? pb_w : 8'h00;
    wire [1:0]  widx_w  = cnt_r - {1'b0, pop_w};
    wire [1:0]  cnt_nxt = cnt_r + {1'b0, push_w} - {1'b0, pop_w};
    // Print side buffer writes
    wire        pwe_w   = (st_r == S_SPACE) || (st_r == S_MARK) || (st_r == S_CLEAR) || (st_r == S_INIT);
    logic [7:0] pwa_w, pwd_w;
    assign pwa_w = (st_r == S_SPACE) ? stt_r : (st_r != S_MARK) ? c_r :
                   (stp_r == 2'd0) ? stt_r : (stp_r == 2'd1) ? stt_r + 8'h01 :
                   (stp_r == 2'd2) ? c_r - 8'h01 : c_r - 8'h02;
    assign pwd_w = (st_r == S_SPACE) ? CH_SPACE : (st_r != S_MARK) ? CH_EMPTY :
                   (stp_r[0] == 1'b0) ? SLEW_MARK : (stp_r == 2'd1) ? c_r : stt_r - 8'h01;
    // Answerback next values
    wire        key_acc = key_valid_i && key_ready_o;
    wire        ctrl_w  = key_char_i < CTRL_LIM;
    wire        ab_nxt  = cfg_mode_i && (answerback_program_key_i ? !ab_on_r : ab_on_r);
    wire [1:0]  echo_nxt = key_acc ? (ctrl_w ? 2'd2 : 2'd1) : echo_r - {1'b0, echo_go};

    // Line buffer storage, no reset; cleared by the init pass
    always_ff @(posedge clock_i)
    begin
        if (wr_acc && !ovp_hit)
            mem[fsel_r][wr_col_i] <= wr_char_i;
        if (swap_w && hold_v_r)
            mem[psel_w][hold_col_r] <= hold_chr_r;
        if (pwe_w)
            mem[psel_w][pwa_w] <= pwd_w;
        if (st_r == S_INIT)
            mem[fsel_r][c_r] <= CH_EMPTY;
    end

    // Fill side: pending hand-over and held overprint character
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ready_o <= 1'b0;
            pend_r     <= 1'b0;
            novp_r     <= 1'b0;
            hold_v_r   <= 1'b0;
            hold_col_r <= 8'h00;
            hold_chr_r <= 8'h00;
            nbell_r    <= 4'h0;
            ntone_r    <= TONE_400;
            nlf_r      <= 8'h00;
            fsel_r     <= 1'b0;
        end
        else
        begin
            if (ovp_hit)
            begin
                pend_r     <= 1'b1;
                novp_r     <= 1'b1;
                hold_v_r   <= 1'b1;
                hold_col_r <= wr_col_i;
                hold_chr_r <= wr_char_i;
                nbell_r    <= 4'h0;
                nlf_r      <= 8'h00;
                wr_ready_o <= 1'b0;
            end
            else if (end_acc)
            begin
                pend_r     <= 1'b1;
                novp_r     <= 1'b0;
                hold_v_r   <= 1'b0;
                nbell_r    <= line_bell_i;
                ntone_r    <= line_tone_i;
                nlf_r      <= line_lf_i;
                wr_ready_o <= 1'b0;
            end
            else if (swap_w)
            begin
                pend_r     <= 1'b0;
                hold_v_r   <= 1'b0;
                fsel_r     <= ~fsel_r;
                wr_ready_o <= 1'b1;
            end
            else if (st_r == S_INIT && c_r == LAST_COL)
                wr_ready_o <= 1'b1;
        end
    end

    // Print process
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= S_INIT;
            {c_r, lft_r, rgt_r, last_r, run_r, stt_r} <= 48'h0;
            {stp_r, rev_r, fnd_r, ovp_r, brk_r, pvm_r} <= 7'h00;
            {bell_r, tone_r, lf_r} <= 13'h0000;
        end
        else
        begin
            unique case (st_r)
                S_INIT, S_CLEAR:
                begin
                    c_r  <= (c_r == LAST_COL) ? 8'h00 : c_r + 8'h01;
                    st_r <= (c_r == LAST_COL) ? S_IDLE : st_r;
                    fnd_r <= 1'b0;
                end
                S_IDLE:
                    if (swap_w)
                    begin
                        brk_r  <= pvm_r && (nlf_r != 8'h00) && !novp_r;
                        pvm_r  <= (nlf_r != 8'h00);
                        ovp_r  <= novp_r;
                        bell_r <= nbell_r;
                        tone_r <= ntone_r;
                        lf_r   <= nlf_r;
                        c_r    <= 8'h00;
                        st_r   <= S_FIND;
                    end
                S_FIND:
                begin
                    lft_r <= lft_w;
                    rgt_r <= rgt_w;
                    fnd_r <= fnd_w;
                    c_r   <= (c_r == LAST_COL) ? lft_w : c_r + 8'h01;
                    run_r <= 8'h00;
                    if (c_r == LAST_COL)
                    begin
                        rev_r <= rev_w;
                        st_r  <= fnd_w ? S_COMP : S_DIR;
                    end
                end
                S_COMP:
                    if (pb_w == CH_EMPTY)
                    begin
                        stt_r <= (run_r == 8'h00) ? c_r : stt_r;
                        run_r <= run_r + 8'h01;
                        c_r   <= c_r + 8'h01;
                    end
                    else if (run_r >= SLEW_RUN)
                    begin
                        stp_r <= 2'd0;
                        st_r  <= S_MARK;
                    end
                    else if (run_r != 8'h00)
                        st_r <= S_SPACE;
                    else if (c_r == rgt_r)
                    begin
                        c_r  <= rev_r ? rgt_r : lft_r;
                        st_r <= S_DIR;
                    end
                    else
                        c_r <= c_r + 8'h01;
                S_SPACE:
                begin
                    stt_r <= stt_r + 8'h01;
                    run_r <= 8'h00;
                    st_r  <= (stt_r + 8'h01 == c_r) ? S_COMP : S_SPACE;
                end
                S_MARK:
                begin
                    stp_r <= stp_r + 2'd1;
                    run_r <= 8'h00;
                    st_r  <= (stp_r == 2'd3) ? S_COMP : S_MARK;
                end
                S_DIR:
                    st_r <= prn_go ? S_BELL : S_DIR;
                S_BELL:
                    if (bell_r == 4'h0 || prn_go)
                        st_r <= fnd_r ? S_EMIT : S_LF;
                S_EMIT:
                    if (prn_go)
                    begin
                        c_r <= (pb_w == SLEW_MARK) ? nx_w : step_w;
                        if (pb_w != SLEW_MARK && c_r == end_w)
                        begin
                            last_r <= c_r;
                            st_r   <= S_LF;
                        end
                    end
                S_LF:
                    if (lf_r == 8'h00 || prn_go)
                    begin
                        c_r  <= 8'h00;
                        st_r <= S_CLEAR;
                    end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // Two-entry output buffer, head drives the ports
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r       <= 2'd0;
            out_valid_o <= 1'b0;
            {out_kind_o, k1_r} <= {K_DIR, K_DIR};
            {out_col_o, out_data_o, c1_r, d1_r} <= 32'h0;
        end
        else
        begin
            cnt_r       <= cnt_nxt;
            out_valid_o <= (cnt_nxt != 2'd0);
            if (push_w && widx_w == 2'd0)
                {out_kind_o, out_col_o, out_data_o} <= {pk_w, pc_w, pd_w};
            else if (pop_w)
                {out_kind_o, out_col_o, out_data_o} <= {k1_r, c1_r, d1_r};
            if (push_w && widx_w == 2'd1)
                {k1_r, c1_r, d1_r} <= {pk_w, pc_w, pd_w};
        end
    end

    // Answerback entry and parameter reload
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            {ab_on_r, ab_ovf_r, ab_entry_o, key_ready_o, nv_save_o} <= 5'h00;
            {boot_r, param_load_o, echo_r} <= 4'h0;
            {ab_len_o, echo_chr_r, ab_rd_data_o} <= 21'h0;
        end
        else
        begin
            boot_r       <= 1'b1;
            param_load_o <= !boot_r;
            ab_on_r      <= ab_nxt;
            ab_entry_o   <= ab_nxt;
            echo_r       <= echo_nxt;
            key_ready_o  <= ab_nxt && (echo_nxt == 2'd0);
            nv_save_o    <= answerback_program_key_i && cfg_mode_i && ab_on_r && !ab_ovf_r;
            ab_rd_data_o <= (ab_rd_addr_i < AB_MAX) ? ab_mem[ab_rd_addr_i] : 8'h00;
            if (answerback_program_key_i && cfg_mode_i && !ab_on_r)
            begin
                ab_len_o <= 5'h00;
                ab_ovf_r <= 1'b0;
            end
            else if (key_acc)
            begin
                echo_chr_r <= ctrl_w ? key_char_i + CTRL_OFS : key_char_i;
                if (ab_len_o < AB_MAX)
                begin
                    ab_mem[ab_len_o] <= key_char_i;
                    ab_len_o <= ab_len_o + 5'h01;
                end
                else
                    ab_ovf_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_mark_open;
        st_r == S_MARK && stp_r == 2'd0 && pwd_w == SLEW_MARK && pwa_w == stt_r;
    endsequence
    sequence s_mark_tgt;
        st_r == S_MARK && stp_r == 2'd1 && pwd_w == $past(c_r, 2) && pwa_w == stt_r + 8'h01;
    endsequence
    a_slew_encode: assert property ((st_r == S_COMP && pb_w != CH_EMPTY && run_r >= SLEW_RUN)
        |=> s_mark_open ##1 s_mark_tgt) else $error("slew marker not written");
    a_space_fill: assert property ((st_r == S_SPACE) |-> pwd_w == CH_SPACE && pwa_w < c_r)
        else $error("space fill wrong");
    a_rev_guard: assert property ((st_r == S_DIR && rev_r) |-> brk_r && !ovp_r)
        else $error("illegal reverse line");
    a_near_end: assert property ((st_r == S_FIND && c_r == LAST_COL && brk_r && !ovp_r && fnd_w)
        |=> rev_r == $past(dr_w < dl_w)) else $error("wrong direction");
    a_idle_swap: assert property ((st_r == S_IDLE && pend_r) |=> st_r == S_FIND && wr_ready_o)
        else $error("hand-over missed");
    a_slew_jump: assert property ((st_r == S_EMIT && prn_go && pb_w == SLEW_MARK)
        |-> pk_w == K_SLEW ##1 c_r == $past(nx_w)) else $error("slew not taken");
    a_caret_echo: assert property ((key_acc && ctrl_w) |=> echo_r == 2'd2 && echo_chr_r == $past(key_char_i) + CTRL_OFS)
        else $error("control echo wrong");
    a_ab_save: assert property ((answerback_program_key_i && cfg_mode_i && ab_on_r)
        |=> nv_save_o == !$past(ab_ovf_r) && !ab_entry_o) else $error("save decision wrong");
    a_boot_load: assert property (!boot_r |=> param_load_o ##1 !param_load_o)
        else $error("parameter reload missing");
endmodule : pls_top

/* File: bench/pls_sink.sv */
`timescale 1ns/1ps
// Carriage, stepper and bell side: takes print words, slowly on request
module pls_sink
    import pls_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       slow_i,     // Accept one word in four
    input  wire logic       valid_i,
    input  wire pls_kind_t  kind_i,
    input  wire logic [7:0] col_i,
    input  wire logic [7:0] data_i,
    output logic            ready_o = 1'b0
);
    logic [18:0] words [0:255];  // Accepted words as {kind, col, data}
    int          count = 0;      // Number of words accepted
    logic [1:0]  pace_r = 2'h0;  // Stall pacing counter

    // Record each word at the edge it is taken, then pace ready
    always @(posedge clock_i)
    begin
        if (valid_i === 1'b1 && ready_o === 1'b1 && count < 256)
        begin
            words[count] = {kind_i, col_i, data_i};
            count++;
        end
        #2;
        pace_r = pace_r + 2'h1;
        ready_o = !sys_rst_i && (!slow_i || pace_r == 2'h0);
    end
endmodule : pls_sink

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import pls_pkg::*;
    logic       clock_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
    logic       wr_valid_i = 1'b0, line_end_i = 1'b0, line_tone_i = 1'b0;
    logic [7:0] wr_col_i = 8'h00, wr_char_i = 8'h00, line_lf_i = 8'h00, key_char_i = 8'h00;
    logic [3:0] line_bell_i = 4'h0;
    logic       cfg_mode_i = 1'b0, answerback_program_key_i = 1'b0, key_valid_i = 1'b0;
    logic [4:0] ab_rd_addr_i = 5'h00;
    logic       wr_ready_o, out_valid_o, out_ready_i, key_ready_o, ab_entry_o, nv_save_o, param_load_o;
    pls_kind_t  out_kind_o;
    logic [7:0] out_col_o, out_data_o, ab_rd_data_o;
    logic [4:0] ab_len_o;
    int         num_errors = 0, checks = 0, rd = 0;

    // 40 MHz system clock
    always #12.5 clock_i = ~clock_i;

    pls_top dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wr_valid_i(wr_valid_i), .wr_col_i(wr_col_i),
        .wr_char_i(wr_char_i), .line_end_i(line_end_i), .line_bell_i(line_bell_i), .line_tone_i(line_tone_i),
        .line_lf_i(line_lf_i), .wr_ready_o(wr_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_kind_o(out_kind_o), .out_col_o(out_col_o), .out_data_o(out_data_o), .cfg_mode_i(cfg_mode_i),
        .answerback_program_key_i(answerback_program_key_i), .key_valid_i(key_valid_i),
        .key_char_i(key_char_i), .key_ready_o(key_ready_o), .ab_entry_o(ab_entry_o), .ab_len_o(ab_len_o),
        .ab_rd_addr_i(ab_rd_addr_i), .ab_rd_data_o(ab_rd_data_o), .nv_save_o(nv_save_o),
        .param_load_o(param_load_o));

    pls_sink sink_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .valid_i(out_valid_o),
        .kind_i(out_kind_o), .col_i(out_col_o), .data_i(out_data_o), .ready_o(out_ready_i));

    // Verdict and end of run
    task automatic test_done;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // One comparison
    task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Condition polled by the bounded wait
    function automatic logic pick(input int s);
        case (s)
            0: return wr_ready_o;
            1: return key_ready_o;
            2: return ab_entry_o;
            default: return sink_u.count > rd;
        endcase
    endfunction : pick

    // Wait for a condition at a rising edge, bounded
    task automatic await(input int s);
        int i;
        for (i = 0; i < 5000; i++)
        begin
            @(posedge clock_i);
            if (pick(s) === 1'b1)
                break;
        end
        if (i == 5000)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            test_done();
        end
        #2;
    endtask : await

    // Deposit one character; valid stays up for the next deposit
    task automatic put(input logic [7:0] c, input logic [7:0] ch);
        wr_valid_i = 1'b1;
        wr_col_i = c;
        wr_char_i = ch;
        await(0);
    endtask : put

    // Close the line with bell, tone and line-feed steps
    task automatic fin(input logic [3:0] b, input logic t, input logic [7:0] lf);
        wr_valid_i = 1'b0;
        line_end_i = 1'b1;
        line_bell_i = b;
        line_tone_i = t;
        line_lf_i = lf;
        await(0);
        line_end_i = 1'b0;
    endtask : fin

    // Next word at the head side; col only for CHAR and SLEW
    task automatic ew(input pls_kind_t k, input logic [7:0] c, input logic [7:0] d);
        logic [18:0] w;
        await(3);
        w = sink_u.words[rd];
        rd++;
        if (k != K_CHAR && k != K_SLEW)
            w[15:8] = 8'h00;
        if (k == K_SLEW)
            w[7:0] = 8'h00;
        cmp(w, {k, c, d});
    endtask : ew

    // Answerback character, one per echo completion
    task automatic key(input logic [7:0] ch);
        key_valid_i = 1'b1;
        key_char_i = ch;
        await(1);
        key_valid_i = 1'b0;
        @(posedge clock_i);
        #2;
    endtask : key

    // One-cycle press of the program key
    task automatic pkey;
        answerback_program_key_i = 1'b1;
        @(posedge clock_i);
        #2;
        answerback_program_key_i = 1'b0;
    endtask : pkey

    // Count nv_save pulses over a few cycles
    task automatic saves(output int n);
        n = 0;
        repeat (8)
        begin
            @(posedge clock_i);
            n += int'(nv_save_o === 1'b1);
        end
        #2;
    endtask : saves

    // Reset, reload pulse, first line forward with bell and slew under stall
    task automatic t_fwd;
        int n;
        repeat (16) @(posedge clock_i);
        cmp({out_valid_o, wr_ready_o, nv_save_o, param_load_o}, 19'h0);
        #2;
        sys_rst_i = 1'b0;
        n = 0;
        repeat (6)
        begin
            @(posedge clock_i);
            n += int'(param_load_o === 1'b1);
        end
        cmp(n, 1);
        #2;
        slow = 1'b1;
        put(8'h00, 8'h41);
        put(8'h0a, 8'h42);
        fin(4'h2, TONE_2400, 8'h01);
        ew(K_DIR, 8'h00, 8'h00);
        ew(K_BELL, 8'h00, 8'h12);
        ew(K_CHAR, 8'h00, 8'h41);
        ew(K_SLEW, 8'h0a, 8'h00);
        ew(K_CHAR, 8'h0a, 8'h42);
        ew(K_LF, 8'h00, 8'h01);
        slow = 1'b0;
        $display("test fwd done");
    endtask : t_fwd

    // Overprint forces a partial line out, forward even with right end nearer
    task automatic t_over;
        put(8'h02, 8'h58);
        put(8'h0c, 8'h5a);
        put(8'h0c, 8'h59);
        fin(4'h0, TONE_400, 8'h01);
        ew(K_DIR, 8'h00, 8'h00);
        ew(K_CHAR, 8'h02, 8'h58);
        ew(K_SLEW, 8'h0c, 8'h00);
        ew(K_CHAR, 8'h0c, 8'h5a);
        ew(K_DIR, 8'h00, 8'h00);
        ew(K_CHAR, 8'h0c, 8'h59);
        ew(K_LF, 8'h00, 8'h01);
        $display("test over done");
    endtask : t_over

    // Bracketed lines: nearer right end reverses, then a tie goes forward
    task automatic t_dir;
        put(8'h03, 8'h61);
        put(8'h14, 8'h62);
        fin(4'h0, TONE_400, 8'h01);
        put(8'h01, 8'h63);
        put(8'h05, 8'h64);
        fin(4'h0, TONE_400, 8'h01);
        ew(K_DIR, 8'h00, 8'h01);
        ew(K_CHAR, 8'h14, 8'h62);
        ew(K_SLEW, 8'h03, 8'h00);
        ew(K_CHAR, 8'h03, 8'h61);
        ew(K_LF, 8'h00, 8'h01);
        ew(K_DIR, 8'h00, 8'h00);
        ew(K_CHAR, 8'h01, 8'h63);
        ew(K_CHAR, 8'h02, CH_SPACE);
        ew(K_CHAR, 8'h03, CH_SPACE);
        ew(K_CHAR, 8'h04, CH_SPACE);
        ew(K_CHAR, 8'h05, 8'h64);
        ew(K_LF, 8'h00, 8'h01);
        $display("test dir done");
    endtask : t_dir

    // Answerback entry: echo, save on second press, no save on exit
    task automatic t_ab;
        int n;
        cfg_mode_i = 1'b1;
        pkey();
        await(2);
        key(8'h61);
        key(8'h01);
        ew(K_ECHO, 8'h00, 8'h61);
        ew(K_ECHO, 8'h00, CARET);
        ew(K_ECHO, 8'h00, 8'h41);
        pkey();
        saves(n);
        cmp(n, 1);
        cmp({ab_entry_o, ab_len_o}, 6'h02);
        ab_rd_addr_i = 5'h01;
        repeat (2) @(posedge clock_i);
        #2;
        cmp(ab_rd_data_o, 8'h01);
        pkey();
        await(2);
        key(8'h42);
        ew(K_ECHO, 8'h00, 8'h42);
        cfg_mode_i = 1'b0;
        saves(n);
        cmp(n, 0);
        ab_rd_addr_i = 5'h00;
        repeat (2) @(posedge clock_i);
        #2;
        cmp({ab_entry_o, ab_rd_data_o}, 9'h042);
        cmp(sink_u.count, rd);
        $display("test ab done");
    endtask : t_ab

    // Main sequence
    initial
    begin
        #2;
        t_fwd();
        t_over();
        t_dir();
        t_ab();
        test_done();
    end
endmodule : tb
